// ==== verilog/srfc_pkg.sv ====
// constants, types and helper function for the serial frame check and command map
// Summary of operation
// - ascii mode: sum address, function and data bytes modulo 256
// - ascii check value is the two's-complement negation of that sum
// - rtu cyclic check register starts each message at all ones
// - each byte is xored into the register low byte before shifting
// - shift right, zero into msb; xor reflected polynomial when lsb was one
// - exactly eight shifts per byte before the next byte enters
// - register contents after the last message byte are the rtu check value
// - rtu check value goes out low byte first, then high byte
// - parameter address: high byte is group, low byte is index
// - command run field: none, stop, run, jog plus run; bits 2-3 reserved
// - command direction field: none, forward, reverse, toggle direction
// - ramp field selects first or second accel/decel set; bits 8-15 reserved
// - fault register: bit 0 raises external fault, bit 1 requests reset
// - error code reads 0 with no error, 1 after an over-current fault
// - ascii fields travel as two hex characters; sum uses decoded bytes
// - address zero is broadcast: act on it but never reply
package srfc_pkg;

    // cyclic check arithmetic
    localparam logic [15:0] SRFC_CRC_PRESET      = 16'hffff;
    localparam logic [15:0] SRFC_CRC_POLY        = 16'ha001;
    localparam logic [3:0]  SRFC_LAST_SHIFT      = 4'h7;
    localparam logic [7:0]  SRFC_LRC_RST         = 8'h00;

    // addressing and function codes
    localparam logic [7:0]  SRFC_BCAST_ADDR      = 8'h00;
    localparam logic [7:0]  SRFC_FN_READ         = 8'h03;
    localparam logic [7:0]  SRFC_FN_WRITE        = 8'h06;
    localparam logic [15:0] SRFC_READ_ONE        = 16'h0001;

    // register offsets
    localparam logic [15:0] SRFC_DRIVE_COMMAND   = 16'h2000;
    localparam logic [15:0] SRFC_FREQ_SETPOINT   = 16'h2001;
    localparam logic [15:0] SRFC_FAULT_RESET_REQ = 16'h2002;
    localparam logic [15:0] SRFC_ERROR_STATUS    = 16'h2100;

    // field positions
    localparam int unsigned SRFC_RUN_LSB         = 0;
    localparam int unsigned SRFC_DIR_LSB         = 4;
    localparam int unsigned SRFC_RAMP_LSB        = 6;
    localparam int unsigned SRFC_EXT_FAULT_BIT   = 0;
    localparam int unsigned SRFC_RESET_BIT       = 1;

    // two-bit field codes
    localparam logic [1:0]  SRFC_CODE_NONE       = 2'h0;
    localparam logic [1:0]  SRFC_CODE_ONE        = 2'h1;
    localparam logic [1:0]  SRFC_CODE_TWO        = 2'h2;
    localparam logic [1:0]  SRFC_CODE_BOTH       = 2'h3;

    // error codes and reset values
    localparam logic [15:0] SRFC_ERR_NONE        = 16'h0000;
    localparam logic [15:0] SRFC_ERR_OVERCURRENT = 16'h0001;
    localparam logic [15:0] SRFC_SETPOINT_RST    = 16'h0000;

    // frame byte counts
    localparam logic [5:0]  SRFC_BODY_BYTES      = 6'h06;
    localparam logic [5:0]  SRFC_MIN_MSG_BYTES   = 6'h02;
    localparam logic [5:0]  SRFC_CHK_ASCII       = 6'h01;
    localparam logic [5:0]  SRFC_CHK_RTU         = 6'h02;
    localparam logic [5:0]  SRFC_IDX_MAX         = 6'h3f;

    // fifo shape
    localparam int unsigned SRFC_FIFO_DEPTH      = 8;
    localparam int unsigned SRFC_FIFO_WIDTH      = 9;

    typedef enum logic [1:0] {
        SRFC_ST_RECV = 2'b01,
        SRFC_ST_EVAL = 2'b10
    } srfc_state_t;

    // nibble to ascii hex character
    function automatic logic [7:0] srfc_hex_char(input logic [3:0] nib);
        srfc_hex_char = (nib < 4'ha) ? (8'h30 + {4'h0, nib}) : (8'h37 + {4'h0, nib});
    endfunction

endpackage

// ==== verilog/srfc_fifo.sv ====
// byte fifo between the receive stream and the check engine
`timescale 1ns/1ps
module srfc_fifo
    import srfc_pkg::*;
#(
    parameter int unsigned WIDTH = SRFC_FIFO_WIDTH,
    parameter int unsigned DEPTH = SRFC_FIFO_DEPTH
) (
    // clock and reset
    input  wire logic             clk_in,
    input  wire logic             rst_n_in,
    // fill side
    input  wire logic             in_valid_in,
    input  wire logic [WIDTH-1:0] in_data_in,
    output logic                  in_ready_out,
    // drain side
    output logic                  out_valid_out,
    output logic [WIDTH-1:0]      out_data_out,
    input  wire logic             out_ready_in
);
    localparam int unsigned AW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem_r [DEPTH];
    logic [AW-1:0]    wr_ptr_r;
    logic [AW-1:0]    rd_ptr_r;
    logic [AW:0]      count_r;
    logic [AW:0]      count_nxt;
    wire              push = in_valid_in && in_ready_out;
    wire              pop  = out_valid_out && out_ready_in;

    // occupancy next value
    assign count_nxt     = count_r + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
    assign out_data_out  = mem_r[rd_ptr_r];

    // pointers, count and registered flags
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            wr_ptr_r      <= '0;
            rd_ptr_r      <= '0;
            count_r       <= '0;
            in_ready_out  <= 1'b1;
            out_valid_out <= 1'b0;
        end else begin
            if (push) begin
                wr_ptr_r <= (wr_ptr_r == AW'(DEPTH - 1)) ? '0 : wr_ptr_r + 1'b1;
            end
            if (pop) begin
                rd_ptr_r <= (rd_ptr_r == AW'(DEPTH - 1)) ? '0 : rd_ptr_r + 1'b1;
            end
            count_r       <= count_nxt;
            in_ready_out  <= (count_nxt != (AW+1)'(DEPTH));
            out_valid_out <= (count_nxt != '0);
        end
    end

    // storage, no reset needed
    always_ff @(posedge clk_in) begin
        if (push) begin
            mem_r[wr_ptr_r] <= in_data_in;
        end
    end

endmodule

// ==== verilog/srfc_check_unit.sv ====
// bitwise cyclic check and longitudinal sum engine, one byte per nine cycles
`timescale 1ns/1ps
module srfc_check_unit
    import srfc_pkg::*;
(
    // clock and reset
    input  wire logic        clk_in,
    input  wire logic        rst_n_in,
    // byte input
    input  wire logic        byte_valid_in,
    input  wire logic        byte_first_in,
    input  wire logic [7:0]  byte_in,
    output logic             byte_ready_out,
    // running check values
    output logic [15:0]      crc_out,
    output logic [7:0]       lrc_out
);
    logic [3:0]  shift_cnt_r;
    logic        busy_r;
    wire         accept    = byte_valid_in && !busy_r;
    wire [15:0]  crc_base  = byte_first_in ? SRFC_CRC_PRESET : crc_out;
    wire [7:0]   lrc_base  = byte_first_in ? SRFC_LRC_RST : lrc_out;
    wire [15:0]  crc_shift = {1'b0, crc_out[15:1]} ^ (crc_out[0] ? SRFC_CRC_POLY : 16'h0000);

    assign byte_ready_out = !busy_r;

    // load byte, then shift eight times
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            crc_out     <= SRFC_CRC_PRESET;
            lrc_out     <= SRFC_LRC_RST;
            shift_cnt_r <= 4'h0;
            busy_r      <= 1'b0;
        end else if (accept) begin
            crc_out     <= crc_base ^ {8'h00, byte_in};
            lrc_out     <= lrc_base + byte_in;
            shift_cnt_r <= 4'h0;
            busy_r      <= 1'b1;
        end else if (busy_r) begin
            crc_out     <= crc_shift;
            shift_cnt_r <= shift_cnt_r + 4'h1;
            busy_r      <= (shift_cnt_r != SRFC_LAST_SHIFT);
        end
    end

    a_first_preset: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        accept && byte_first_in |=> crc_out == (SRFC_CRC_PRESET ^ {8'h00, $past(byte_in)}))
        else $error("cyclic check not preset before first byte");
    a_shift_step: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        busy_r && crc_out[0] |=> crc_out == (($past(crc_out) >> 1) ^ SRFC_CRC_POLY))
        else $error("shift step with lsb set lacks polynomial");
    a_eight_shifts: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        accept |=> busy_r [*8] ##1 !busy_r)
        else $error("byte not given exactly eight shifts");

endmodule

// ==== verilog/srfc_frame_check.sv ====
// frame check, command decode and error status for the drive serial slave port
`timescale 1ns/1ps
module srfc_frame_check
    import srfc_pkg::*;
(
    // clock and reset
    input  wire logic        CORE_CLK_IN,
    input  wire logic        RESETN_IN,
    // decoded receive byte stream
    input  wire logic        RX_VALID_IN,
    input  wire logic [7:0]  RX_DATA_IN,
    input  wire logic        RX_LAST_IN,
    output logic             RX_READY_OUT,
    // configuration
    input  wire logic        RTU_MODE_IN,
    input  wire logic [7:0]  NODE_ADDR_IN,
    // fault pin
    input  wire logic        OVER_CURRENT_FAULT_IN,
    // frame verdict and check value
    output logic             FRAME_GOOD_OUT,
    output logic             FRAME_BAD_OUT,
    output logic             REPLY_REQ_OUT,
    output logic [15:0]      CHECK_VALUE_OUT,
    output logic [7:0]       CHECK_FIRST_OUT,
    output logic [7:0]       CHECK_SECOND_OUT,
    output logic [7:0]       LRC_CHAR_HI_OUT,
    output logic [7:0]       LRC_CHAR_LO_OUT,
    // drive command
    output logic             RUN_REQ_OUT,
    output logic             STOP_REQ_OUT,
    output logic             JOG_REQ_OUT,
    output logic             REVERSE_ROTATION_OUT,
    output logic             RAMP_SET2_OUT,
    output logic [15:0]      FREQUENCY_SETPOINT_OUT,
    output logic             EXTERNAL_FAULT_TRIGGER_OUT,
    output logic             FAULT_RESET_OUT,
    // parameter access
    output logic             PARAM_WRITE_OUT,
    output logic             PARAM_READ_OUT,
    output logic [7:0]       PARAMETER_GROUP_OUT,
    output logic [7:0]       PARAMETER_INDEX_OUT,
    output logic [15:0]      PARAM_DATA_OUT,
    // status read
    output logic             STATUS_READ_OUT,
    output logic [15:0]      ERROR_CODE_OUT
);

    ////////////////////////////////////////////////////////////////////////////
    // byte path: fifo then check engine

    srfc_state_t state_r;
    logic [8:0]  fo_data;
    logic        fo_valid;
    logic        chk_ready;
    logic [15:0] crc_now;
    logic [7:0]  lrc_now;
    logic [5:0]  idx_r;

    wire         in_recv  = (state_r == SRFC_ST_RECV);
    wire         pop      = fo_valid && chk_ready && in_recv;
    wire         first    = (idx_r == 6'h00);
    wire         fo_last  = fo_data[8];
    wire [7:0]   fo_byte  = fo_data[7:0];

    srfc_fifo #(
        .WIDTH (SRFC_FIFO_WIDTH),
        .DEPTH (SRFC_FIFO_DEPTH)
    ) u_fifo (
        .clk_in        (CORE_CLK_IN),
        .rst_n_in      (RESETN_IN),
        .in_valid_in   (RX_VALID_IN),
        .in_data_in    ({RX_LAST_IN, RX_DATA_IN}),
        .in_ready_out  (RX_READY_OUT),
        .out_valid_out (fo_valid),
        .out_data_out  (fo_data),
        .out_ready_in  (chk_ready && in_recv)
    );

    srfc_check_unit u_check (
        .clk_in         (CORE_CLK_IN),
        .rst_n_in       (RESETN_IN),
        .byte_valid_in  (fo_valid && in_recv),
        .byte_first_in  (first),
        .byte_in        (fo_byte),
        .byte_ready_out (chk_ready),
        .crc_out        (crc_now),
        .lrc_out        (lrc_now)
    );

    ////////////////////////////////////////////////////////////////////////////
    // frame capture

    logic [7:0]  addr_r;
    logic [7:0]  func_r;
    logic [7:0]  body_r [4];
    logic [7:0]  byte_last_r;
    logic [7:0]  byte_prev_r;
    logic [15:0] crc_p1_r;
    logic [15:0] crc_p2_r;
    logic [7:0]  lrc_p1_r;
    logic [5:0]  len_r;

    // capture bytes and check values as they were before each byte
    always_ff @(posedge CORE_CLK_IN or negedge RESETN_IN) begin
        if (!RESETN_IN) begin
            idx_r       <= 6'h00;
            len_r       <= 6'h00;
            addr_r      <= 8'h00;
            func_r      <= 8'h00;
            body_r      <= '{default: 8'h00};
            byte_last_r <= 8'h00;
            byte_prev_r <= 8'h00;
            crc_p1_r    <= SRFC_CRC_PRESET;
            crc_p2_r    <= SRFC_CRC_PRESET;
            lrc_p1_r    <= SRFC_LRC_RST;
        end else if (pop) begin
            idx_r       <= fo_last ? 6'h00 : ((idx_r == SRFC_IDX_MAX) ? idx_r : idx_r + 6'h01);
            len_r       <= (idx_r == SRFC_IDX_MAX) ? idx_r : idx_r + 6'h01;
            if (idx_r == 6'h00) addr_r <= fo_byte;
            if (idx_r == 6'h01) func_r <= fo_byte;
            if (idx_r >= 6'h02 && idx_r < SRFC_BODY_BYTES) body_r[idx_r[1:0] - 2'h2] <= fo_byte;
            byte_last_r <= fo_byte;
            byte_prev_r <= byte_last_r;
            crc_p1_r    <= first ? SRFC_CRC_PRESET : crc_now;
            crc_p2_r    <= crc_p1_r;
            lrc_p1_r    <= first ? SRFC_LRC_RST : lrc_now;
        end
    end

    // receive until last byte, then one evaluation cycle
    always_ff @(posedge CORE_CLK_IN or negedge RESETN_IN) begin
        if (!RESETN_IN) begin
            state_r <= SRFC_ST_RECV;
        end else begin
            case (state_r)
                SRFC_ST_RECV: if (pop && fo_last) state_r <= SRFC_ST_EVAL;
                SRFC_ST_EVAL: state_r <= SRFC_ST_RECV;
                default:      state_r <= SRFC_ST_RECV;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // evaluation decode

    wire [5:0]  chk_len   = RTU_MODE_IN ? SRFC_CHK_RTU : SRFC_CHK_ASCII;
    wire [5:0]  msg_len   = len_r - chk_len;
    wire        len_ok    = (len_r >= chk_len + SRFC_MIN_MSG_BYTES);
    wire [7:0]  lrc_neg   = 8'h00 - lrc_p1_r;
    wire        rtu_ok    = (crc_p2_r == {byte_last_r, byte_prev_r});
    wire        ascii_ok  = (lrc_neg == byte_last_r);
    wire        frame_ok  = len_ok && (RTU_MODE_IN ? rtu_ok : ascii_ok);
    wire        is_bcast  = (addr_r == SRFC_BCAST_ADDR);
    wire        addressed = is_bcast || (addr_r == NODE_ADDR_IN);
    wire        evaluate  = (state_r == SRFC_ST_EVAL);
    wire        accepted  = evaluate && frame_ok && addressed;
    wire [15:0] reg_addr  = {body_r[0], body_r[1]};
    wire [15:0] wr_data   = {body_r[2], body_r[3]};
    wire        body_len  = (msg_len == SRFC_BODY_BYTES);
    wire        do_write  = accepted && body_len && (func_r == SRFC_FN_WRITE);
    wire        do_read   = accepted && body_len && (func_r == SRFC_FN_READ) && (wr_data == SRFC_READ_ONE);
    wire        wr_cmd    = do_write && (reg_addr == SRFC_DRIVE_COMMAND);
    wire        wr_freq   = do_write && (reg_addr == SRFC_FREQ_SETPOINT);
    wire        wr_fault  = do_write && (reg_addr == SRFC_FAULT_RESET_REQ);
    wire        rd_status = do_read && (reg_addr == SRFC_ERROR_STATUS);
    wire        own_reg   = (reg_addr == SRFC_DRIVE_COMMAND) || (reg_addr == SRFC_FREQ_SETPOINT)
                            || (reg_addr == SRFC_FAULT_RESET_REQ) || (reg_addr == SRFC_ERROR_STATUS);
    wire [1:0]  run_fld   = wr_data[SRFC_RUN_LSB +: 2];
    wire [1:0]  dir_fld   = wr_data[SRFC_DIR_LSB +: 2];
    wire [1:0]  ramp_fld  = wr_data[SRFC_RAMP_LSB +: 2];
    wire        rst_req   = wr_fault && wr_data[SRFC_RESET_BIT];

    ////////////////////////////////////////////////////////////////////////////
    // verdict, check value and reply request

    always_ff @(posedge CORE_CLK_IN or negedge RESETN_IN) begin
        if (!RESETN_IN) begin
            FRAME_GOOD_OUT   <= 1'b0;
            FRAME_BAD_OUT    <= 1'b0;
            REPLY_REQ_OUT    <= 1'b0;
            CHECK_VALUE_OUT  <= SRFC_CRC_PRESET;
            CHECK_FIRST_OUT  <= 8'h00;
            CHECK_SECOND_OUT <= 8'h00;
            LRC_CHAR_HI_OUT  <= 8'h30;
            LRC_CHAR_LO_OUT  <= 8'h30;
        end else begin
            FRAME_GOOD_OUT   <= accepted;
            FRAME_BAD_OUT    <= evaluate && !frame_ok;
            REPLY_REQ_OUT    <= (do_write || do_read) && !is_bcast;
            if (evaluate) begin
                CHECK_VALUE_OUT  <= RTU_MODE_IN ? crc_p2_r : {8'h00, lrc_neg};
                CHECK_FIRST_OUT  <= RTU_MODE_IN ? crc_p2_r[7:0] : lrc_neg;
                CHECK_SECOND_OUT <= RTU_MODE_IN ? crc_p2_r[15:8] : 8'h00;
                LRC_CHAR_HI_OUT  <= srfc_hex_char(lrc_neg[7:4]);
                LRC_CHAR_LO_OUT  <= srfc_hex_char(lrc_neg[3:0]);
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // command register decode

    always_ff @(posedge CORE_CLK_IN or negedge RESETN_IN) begin
        if (!RESETN_IN) begin
            RUN_REQ_OUT                <= 1'b0;
            STOP_REQ_OUT               <= 1'b0;
            JOG_REQ_OUT                <= 1'b0;
            REVERSE_ROTATION_OUT       <= 1'b0;
            RAMP_SET2_OUT              <= 1'b0;
            FREQUENCY_SETPOINT_OUT     <= SRFC_SETPOINT_RST;
            EXTERNAL_FAULT_TRIGGER_OUT <= 1'b0;
            FAULT_RESET_OUT            <= 1'b0;
        end else begin
            RUN_REQ_OUT  <= wr_cmd && run_fld[1];
            STOP_REQ_OUT <= wr_cmd && (run_fld == SRFC_CODE_ONE);
            JOG_REQ_OUT  <= wr_cmd && (run_fld == SRFC_CODE_BOTH);
            if (wr_cmd) begin
                case (dir_fld)
                    SRFC_CODE_ONE:  REVERSE_ROTATION_OUT <= 1'b0;
                    SRFC_CODE_TWO:  REVERSE_ROTATION_OUT <= 1'b1;
                    SRFC_CODE_BOTH: REVERSE_ROTATION_OUT <= !REVERSE_ROTATION_OUT;
                    default:        REVERSE_ROTATION_OUT <= REVERSE_ROTATION_OUT;
                endcase
                if (ramp_fld == SRFC_CODE_NONE) RAMP_SET2_OUT <= 1'b0;
                if (ramp_fld == SRFC_CODE_ONE) RAMP_SET2_OUT <= 1'b1;
            end
            if (wr_freq) FREQUENCY_SETPOINT_OUT <= wr_data;
            EXTERNAL_FAULT_TRIGGER_OUT <= wr_fault && wr_data[SRFC_EXT_FAULT_BIT];
            FAULT_RESET_OUT            <= rst_req;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // parameter access and error status

    logic fault_meta_r;
    logic fault_sync_r;
    logic fault_seen_r;

    always_ff @(posedge CORE_CLK_IN or negedge RESETN_IN) begin
        if (!RESETN_IN) begin
            PARAM_WRITE_OUT     <= 1'b0;
            PARAM_READ_OUT      <= 1'b0;
            PARAMETER_GROUP_OUT <= 8'h00;
            PARAMETER_INDEX_OUT <= 8'h00;
            PARAM_DATA_OUT      <= 16'h0000;
            STATUS_READ_OUT     <= 1'b0;
        end else begin
            PARAM_WRITE_OUT <= do_write && !own_reg;
            PARAM_READ_OUT  <= do_read && !own_reg;
            STATUS_READ_OUT <= rd_status;
            if ((do_write || do_read) && !own_reg) begin
                PARAMETER_GROUP_OUT <= reg_addr[15:8];
                PARAMETER_INDEX_OUT <= reg_addr[7:0];
                PARAM_DATA_OUT      <= wr_data;
            end
        end
    end

    // fault pin synchroniser, sticky flag where a new fault beats reset
    always_ff @(posedge CORE_CLK_IN or negedge RESETN_IN) begin
        if (!RESETN_IN) begin
            fault_meta_r   <= 1'b0;
            fault_sync_r   <= 1'b0;
            fault_seen_r   <= 1'b0;
            ERROR_CODE_OUT <= SRFC_ERR_NONE;
        end else begin
            fault_meta_r   <= OVER_CURRENT_FAULT_IN;
            fault_sync_r   <= fault_meta_r;
            fault_seen_r   <= fault_sync_r || (fault_seen_r && !rst_req);
            ERROR_CODE_OUT <= fault_seen_r ? SRFC_ERR_OVERCURRENT : SRFC_ERR_NONE;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // checks

    a_lrc_value: assert property (@(posedge CORE_CLK_IN) disable iff (!RESETN_IN)
        evaluate && !RTU_MODE_IN |=> CHECK_VALUE_OUT == {8'h00, 8'h00 - $past(lrc_p1_r)})
        else $error("ascii check value is not the negated sum");
    a_rtu_order: assert property (@(posedge CORE_CLK_IN) disable iff (!RESETN_IN)
        evaluate && RTU_MODE_IN |=> CHECK_FIRST_OUT == CHECK_VALUE_OUT[7:0]
            && CHECK_SECOND_OUT == CHECK_VALUE_OUT[15:8])
        else $error("rtu check bytes not low first");
    a_bad_no_act: assert property (@(posedge CORE_CLK_IN) disable iff (!RESETN_IN)
        FRAME_BAD_OUT |-> !RUN_REQ_OUT && !STOP_REQ_OUT && !PARAM_WRITE_OUT && !REPLY_REQ_OUT
            && !FAULT_RESET_OUT && !FRAME_GOOD_OUT)
        else $error("corrupt frame acted upon");
    a_bcast_silent: assert property (@(posedge CORE_CLK_IN) disable iff (!RESETN_IN)
        evaluate && is_bcast |=> !REPLY_REQ_OUT)
        else $error("reply requested for broadcast frame");
    a_run_decode: assert property (@(posedge CORE_CLK_IN) disable iff (!RESETN_IN)
        wr_cmd && run_fld == SRFC_CODE_TWO |=> RUN_REQ_OUT && !JOG_REQ_OUT && !STOP_REQ_OUT)
        else $error("run field not decoded as run");
    a_dir_toggle: assert property (@(posedge CORE_CLK_IN) disable iff (!RESETN_IN)
        wr_cmd && dir_fld == SRFC_CODE_BOTH |=> REVERSE_ROTATION_OUT != $past(REVERSE_ROTATION_OUT))
        else $error("change direction did not toggle");
    a_ramp_select: assert property (@(posedge CORE_CLK_IN) disable iff (!RESETN_IN)
        wr_cmd && ramp_fld == SRFC_CODE_ONE |=> RAMP_SET2_OUT)
        else $error("second ramp set not selected");
    a_fault_pulse: assert property (@(posedge CORE_CLK_IN) disable iff (!RESETN_IN)
        wr_fault && wr_data[SRFC_EXT_FAULT_BIT] |=> EXTERNAL_FAULT_TRIGGER_OUT ##1 !EXTERNAL_FAULT_TRIGGER_OUT)
        else $error("external fault not a single pulse");
    a_error_code: assert property (@(posedge CORE_CLK_IN) disable iff (!RESETN_IN)
        $rose(fault_sync_r) |=> ##1 ERROR_CODE_OUT == SRFC_ERR_OVERCURRENT)
        else $error("over-current not reported as code 1");

endmodule

// ==== sim/srfc_master_model.sv ====
// serial master model offering decoded frame bytes to the port
`timescale 1ns/1ps
module srfc_master_model (
    input  wire logic       clk_in,
    input  wire logic       ready_in,
    output logic            valid_out,
    output logic [7:0]      data_out,
    output logic            last_out
);
    // bus idle at time zero
    initial begin
        valid_out = 1'b0;
        data_out  = 8'h00;
        last_out  = 1'b0;
    end
    // one frame, each byte held until taken
    task automatic send(input logic [7:0] fr[10], input int n);
        for (int i = 0; i < n; i++) begin
            valid_out <= 1'b1;
            data_out  <= fr[i];
            last_out  <= (i == n - 1);
            @(posedge clk_in);
            while (ready_in !== 1'b1) @(posedge clk_in);
        end
        valid_out <= 1'b0;
        data_out  <= ~fr[n - 1]; // released bus shows no stale byte
        last_out  <= 1'b0;
    endtask
endmodule

// ==== sim/srfc_frame_check_bench.sv ====
// self-checking bench for the frame check and command map
`timescale 1ns/1ps
module srfc_frame_check_bench;
    import srfc_pkg::*;
    logic        clk, rst_n, mode, ocf, clr, valid, last, ready;
    logic        good, bad, rep, run, stop, jog, rvs, ramp, xf, frst, pwr, prd, stat;
    logic [7:0]  data, c1, c2, lh, ll, grp, idx;
    logic [15:0] cv, sp, pd, ec;
    logic [10:0] cap;
    int          errors, compares;
    srfc_master_model i_srfc_master_model (.clk_in(clk), .ready_in(ready), .valid_out(valid), .data_out(data),
        .last_out(last));
    srfc_frame_check i_srfc_frame_check (.CORE_CLK_IN(clk), .RESETN_IN(rst_n), .RX_VALID_IN(valid),
        .RX_DATA_IN(data), .RX_LAST_IN(last), .RX_READY_OUT(ready), .RTU_MODE_IN(mode), .NODE_ADDR_IN(8'h01),
        .OVER_CURRENT_FAULT_IN(ocf), .FRAME_GOOD_OUT(good), .FRAME_BAD_OUT(bad), .REPLY_REQ_OUT(rep),
        .CHECK_VALUE_OUT(cv), .CHECK_FIRST_OUT(c1), .CHECK_SECOND_OUT(c2), .LRC_CHAR_HI_OUT(lh),
        .LRC_CHAR_LO_OUT(ll), .RUN_REQ_OUT(run), .STOP_REQ_OUT(stop), .JOG_REQ_OUT(jog),
        .REVERSE_ROTATION_OUT(rvs), .RAMP_SET2_OUT(ramp), .FREQUENCY_SETPOINT_OUT(sp),
        .EXTERNAL_FAULT_TRIGGER_OUT(xf), .FAULT_RESET_OUT(frst), .PARAM_WRITE_OUT(pwr), .PARAM_READ_OUT(prd),
        .PARAMETER_GROUP_OUT(grp), .PARAMETER_INDEX_OUT(idx), .PARAM_DATA_OUT(pd), .STATUS_READ_OUT(stat),
        .ERROR_CODE_OUT(ec));
    // clock and sticky capture of every pulse
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    always @(posedge clk) cap <= clr ? 11'h000 : cap | {good, bad, rep, run, stop, jog, xf, frst, pwr, prd, stat};
    task automatic chk(input string nm, input logic [15:0] exp, input logic [15:0] got);
        compares++;
        if (got !== exp) begin
            errors++;
            $display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
        end
    endtask
    function automatic logic [15:0] crc16(input logic [7:0] fr[10], input int n);
        logic [15:0] c;
        c = 16'hffff;
        for (int i = 0; i < n; i++) begin
            c = c ^ {8'h00, fr[i]};
            repeat (8) c = c[0] ? ((c >> 1) ^ 16'ha001) : (c >> 1);
        end
        return c;
    endfunction
    // build, send and judge one frame; x corrupts the check byte
    task automatic frame(input logic m, input logic [7:0] a, f, input logic [15:0] r, d, input logic [7:0] x,
        input logic [10:0] exp);
        logic [7:0]  fr[10];
        logic [15:0] c;
        fr = '{a, f, r[15:8], r[7:0], d[15:8], d[7:0], 8'h00, 8'h00, 8'h00, 8'h00};
        c = crc16(fr, 6);
        fr[6] = (m ? c[7:0] : 8'h00 - (a + f + r[15:8] + r[7:0] + d[15:8] + d[7:0])) ^ x;
        fr[7] = c[15:8];
        mode <= m;
        clr <= 1'b1;
        @(posedge clk);
        clr <= 1'b0;
        i_srfc_master_model.send(fr, m ? 8 : 7);
        for (int k = 0; k < 300 && cap[10:9] == 2'b00; k++) @(posedge clk);
        repeat (3) @(posedge clk);
        chk("pulses", {5'h00, exp}, {5'h00, cap});
    endtask
    task automatic t_check;
        frame(1'b0, 8'h01, 8'h03, 16'h0401, 16'h0001, 8'h00, 11'h502);
        chk("lrc chars", 16'h4636, {lh, ll});
        chk("param addr", 16'h0401, {grp, idx});
        frame(1'b1, 8'h01, 8'h03, 16'h2102, 16'h0002, 8'h00, 11'h400);
        chk("crc", 16'hf76f, cv);
        chk("crc order", 16'h6ff7, {c1, c2});
        $display("check value test done");
    endtask
    task automatic t_cmd;
        logic [10:0] runx[4];
        runx = '{11'h500, 11'h540, 11'h580, 11'h5a0};
        for (int i = 0; i < 4; i++) begin
            frame(1'b1, 8'h01, 8'h06, 16'h2000, 16'hff00 | 16'(i * 8'h55), 8'h00, runx[i]);
            chk("dir ramp", {14'h0, 1'(4'b0100 >> i), 1'(4'b1110 >> i)}, {14'h0, rvs, ramp});
        end
        frame(1'b1, 8'h00, 8'h06, 16'h2001, 16'h1234, 8'h00, 11'h400);
        chk("setpoint", 16'h1234, sp);
        frame(1'b1, 8'h01, 8'h06, 16'h2001, 16'h5678, 8'h01, 11'h200);
        chk("setpoint kept", 16'h1234, sp);
        frame(1'b1, 8'h02, 8'h06, 16'h2001, 16'h9abc, 8'h00, 11'h000);
        chk("setpoint other node", 16'h1234, sp);
        frame(1'b1, 8'h01, 8'h06, 16'h0401, 16'h0007, 8'h00, 11'h504);
        chk("param data", 16'h0007, pd);
        $display("command test done");
    endtask
    task automatic t_fault;
        chk("no error", 16'h0000, ec);
        ocf <= 1'b1;
        repeat (8) @(posedge clk);
        ocf <= 1'b0;
        frame(1'b1, 8'h01, 8'h03, 16'h2100, 16'h0001, 8'h00, 11'h501);
        chk("error code", 16'h0001, ec);
        frame(1'b1, 8'h01, 8'h06, 16'h2002, 16'hffff, 8'h00, 11'h518);
        chk("error cleared", 16'h0000, ec);
        $display("fault test done");
    endtask
    task automatic finish_test;
        $display("errors %0d compares %0d", errors, compares);
        if (errors == 0 && compares > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask
    // reset, then the tests in turn
    initial begin
        {rst_n, mode, ocf, clr, errors, compares} = '0;
        repeat (12) @(posedge clk);
        rst_n <= 1'b1;
        t_check;
        t_cmd;
        t_fault;
        finish_test;
    end
    initial begin
        #100us;
        errors++;
        finish_test;
    end
endmodule
